// ---- core/sdm_att_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface sdm_att_if;
  logic atten_mode;
  logic step_tick;
  logic [1:0] mute;
  logic [1:0][7:0] level;
  logic [1:0][7:0] cur;
  logic [1:0] muted;
  modport ctl (output atten_mode, step_tick, mute, level, input cur, muted);
  modport att (input atten_mode, step_tick, mute, level, output cur, muted);
endinterface
`default_nettype wire

// ---- core/sdm_atten.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "sdm_regs.svh"
module sdm_atten
(
  input wire logic i_clk,
  input wire logic i_rst,
  sdm_att_if.att att
);
  logic [7:0] thr;

  assign thr = att.atten_mode ? `SDM_MUTE_THR_WIDE : `SDM_MUTE_THR_FINE;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++)
    begin : g_ch
      logic [7:0] cur_q;
      logic muted_q;
      logic [7:0] target;

      // mute overrides the programmed level
      assign target = (att.mute[ch] || att.level[ch] <= thr) ? `SDM_ATTEN_MUTE : att.level[ch];
      assign att.cur[ch] = cur_q;
      assign att.muted[ch] = muted_q;

      // one code per step interval, both directions, except jumps across the mute threshold
      always_ff @(posedge i_clk)
      begin
        if (i_rst)
          cur_q <= `SDM_RST_ATTEN_CUR;
        else if (att.step_tick)
        begin
          if (cur_q > target)
          begin
            // stepping to or below the mute threshold the ramp lands on full mute
            if (cur_q <= thr + 8'h01)
              cur_q <= `SDM_ATTEN_MUTE;
            else
              cur_q <= cur_q - 8'h01;
          end
          else if (cur_q < target)
          begin
            // leaving mute resumes from just above the threshold
            if (cur_q <= thr)
              cur_q <= thr + 8'h01;
            else
              cur_q <= cur_q + 8'h01;
          end
        end
      end

      always_ff @(posedge i_clk)
      begin
        if (i_rst)
          muted_q <= 1'b0;
        else
          muted_q <= (cur_q <= thr);
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ---- core/sdm_pkg.sv ----
package sdm_pkg;
  typedef enum logic [1:0] {
    SDM_RATE_AUTO,
    SDM_RATE_SINGLE,
    SDM_RATE_DUAL,
    SDM_RATE_QUAD
  } sdm_rate_e;
endpackage

// ---- core/sdm_rate_det.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "sdm_regs.svh"
module sdm_rate_det
  import sdm_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_restart,
  input wire logic i_fs_edge,
  output sdm_pkg::sdm_rate_e o_rate
);
  logic [10:0] cnt_q;
  logic [10:0] period;
  sdm_rate_e rate_q;

  assign period = cnt_q + 11'h001;
  assign o_rate = rate_q;

  // system clocks per sampling period
  always_ff @(posedge i_clk)
  begin
    if (i_rst || i_restart || i_fs_edge)
      cnt_q <= 11'h000;
    else if (cnt_q != `SDM_RATIO_MAX)
      cnt_q <= cnt_q + 11'h001;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      rate_q <= SDM_RATE_SINGLE;
    else if (i_fs_edge && !i_restart)
    begin
      case (period)
        `SDM_RATIO_S_LO, `SDM_RATIO_S_MID, `SDM_RATIO_S_HI: rate_q <= SDM_RATE_SINGLE;
        `SDM_RATIO_D_LO, `SDM_RATIO_D_HI: rate_q <= SDM_RATE_DUAL;
        `SDM_RATIO_Q_LO, `SDM_RATIO_Q_HI: rate_q <= SDM_RATE_QUAD;
        default: rate_q <= rate_q;
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- core/sdm_regs.svh ----
`ifndef SDM_REGS_SVH
`define SDM_REGS_SVH

// register addresses on the serial control port
`define SDM_ADDR_RST_MUTE_RATE 7'h10
`define SDM_ADDR_PSAVE_FMT 7'h11
`define SDM_ADDR_OPER_FILT 7'h12
`define SDM_ADDR_OUT_PHASE 7'h13
`define SDM_ADDR_SOFT_MUTE 7'h14
`define SDM_ADDR_SILENCE 7'h15
`define SDM_ADDR_ATTEN_FLAG 7'h16

// field positions
`define SDM_BIT_RESTORE 7
`define SDM_BIT_RESYNC 6
`define SDM_POS_MUTE_SRC 2
`define SDM_POS_RATE 0
`define SDM_BIT_PSAVE_SEL 7
`define SDM_POS_FMT 0
`define SDM_BIT_OPDIS 4
`define SDM_BIT_ROLLOFF 0
`define SDM_POS_INVERT 0
`define SDM_POS_SMUTE 0
`define SDM_POS_SILENCE 0
`define SDM_BIT_ATTEN_MODE 7

// reset values
`define SDM_RST_MUTE_SRC 4'h0
`define SDM_RST_RATE 2'h0
`define SDM_RST_PSAVE_SEL 1'h0
`define SDM_RST_FMT 3'h0
`define SDM_RST_OPDIS 1'h0
`define SDM_RST_ROLLOFF 1'h0
`define SDM_RST_INVERT 2'h0
`define SDM_RST_SMUTE 2'h0
`define SDM_RST_ATTEN_MODE 1'h0
`define SDM_RST_ATTEN_CUR 8'hff

// timing counts
`define SDM_STEP_FS_PERIODS 3'h7
`define SDM_RATIO_Q_LO 11'h080
`define SDM_RATIO_Q_HI 11'h0c0
`define SDM_RATIO_D_LO 11'h100
`define SDM_RATIO_D_HI 11'h180
`define SDM_RATIO_S_LO 11'h200
`define SDM_RATIO_S_MID 11'h300
`define SDM_RATIO_S_HI 11'h480
`define SDM_RATIO_MAX 11'h7ff

// attenuation codes at or below these are full mute
`define SDM_MUTE_THR_FINE 8'h80
`define SDM_MUTE_THR_WIDE 8'h9a
`define SDM_ATTEN_MUTE 8'h00

`endif

// ---- core/sdm_top.sv ----
// Function
// - Writing 0 to restore bit loads all defaults
// - Restore bit returns to 1 by itself
// - Writing 0 to resync bit restarts, keeps registers
// - Resync bit returns to 1 by itself
// - Four enables gate analog mute sources
// - Rate field: auto, single, dual, quad
// - Auto mode derives rate from clock ratio
// - Power-save select picks power save or disable
// - Three-bit field selects audio input format
// - Operation disable cuts input, clears data
// - Disable holds common mode or ground, powerdown
// - Control port stays live during disable
// - Roll-off bit: 0 sharp, 1 slow
// - Phase bits invert left and right outputs
// - Soft mute ramps channel to full mute
// - Unmute ramps back to programmed level
// - Soft mute overrides programmed attenuation level
// - Silence bits show live zero detectors
// - Attenuation-mode bit seven, reset zero
// - Mode picks fine (80h) or wide (9Ah) mute threshold
// - Ramps step once per eight sample periods
`timescale 1ns/100ps
`default_nettype none
`include "sdm_regs.svh"
module sdm_top
  import sdm_pkg::*;
(
  input wire logic I_MCLK,
  input wire logic I_SYS_RST,
  input wire logic I_REG_WR,
  input wire logic I_REG_RD,
  input wire logic [6:0] I_REG_ADDR,
  input wire logic [7:0] I_REG_WDATA,
  output logic [7:0] O_REG_RDATA,
  output logic O_REG_RVALID,
  input wire logic I_LRCK,
  input wire logic I_ZERO_L,
  input wire logic I_ZERO_R,
  input wire logic I_CLK_HALT,
  input wire logic I_ASYNC_DET,
  input wire logic [7:0] I_ATTEN_L,
  input wire logic [7:0] I_ATTEN_R,
  output sdm_pkg::sdm_rate_e O_RATE,
  output logic [2:0] O_FORMAT,
  output logic O_ROLLOFF,
  output logic [1:0] O_INVERT,
  output logic O_ATTEN_MODE,
  output logic [7:0] O_ATTEN_L,
  output logic [7:0] O_ATTEN_R,
  output logic [1:0] O_CH_MUTED,
  output logic O_ANALOG_MUTE,
  output logic O_DATA_CLEAR,
  output logic O_HOLD_COMMON,
  output logic O_HOLD_GROUND,
  output logic O_POWER_DOWN,
  output logic O_RESYNC
);
  logic restore_q;
  logic resync_q;
  logic [3:0] mute_src_q;
  logic [1:0] rate_q;
  logic psave_sel_q;
  logic [2:0] fmt_q;
  logic opdis_q;
  logic rolloff_q;
  logic [1:0] invert_q;
  logic [1:0] smute_q;
  logic atten_mode_q;
  logic wr_ok;
  logic [7:0] rd_d;
  logic lr_s1_q;
  logic lr_s2_q;
  logic lr_s3_q;
  logic lr_st_q;
  logic fs_edge;
  logic [2:0] fs_cnt_q;
  logic step_q;
  sdm_rate_e det_rate;

  sdm_att_if att_bus ();

  // register writes, accepted in every operating mode except the cycle when a written restore 0 is pending
  assign wr_ok = I_REG_WR && restore_q;

  // restore: a written 0 is acted on next cycle and reads back as 1
  always_ff @(posedge I_MCLK)
  begin
    if (I_SYS_RST)
      restore_q <= 1'b1;
    else if (!restore_q)
      restore_q <= 1'b1;
    else if (wr_ok && I_REG_ADDR == `SDM_ADDR_RST_MUTE_RATE)
      restore_q <= I_REG_WDATA[`SDM_BIT_RESTORE];
  end

  always_ff @(posedge I_MCLK)
  begin
    if (I_SYS_RST)
      resync_q <= 1'b1;
    else if (!resync_q)
      resync_q <= 1'b1;
    else if (wr_ok && I_REG_ADDR == `SDM_ADDR_RST_MUTE_RATE)
      resync_q <= I_REG_WDATA[`SDM_BIT_RESYNC];
  end

  // one-cycle restart strobe; mode registers untouched
  always_ff @(posedge I_MCLK)
  begin
    if (I_SYS_RST)
      O_RESYNC <= 1'b0;
    else
      O_RESYNC <= !resync_q;
  end

  // reserved positions are not stored
  always_ff @(posedge I_MCLK)
  begin
    if (I_SYS_RST || !restore_q)
    begin
      mute_src_q <= `SDM_RST_MUTE_SRC;
      rate_q <= `SDM_RST_RATE;
    end
    else if (wr_ok && I_REG_ADDR == `SDM_ADDR_RST_MUTE_RATE)
    begin
      mute_src_q <= I_REG_WDATA[`SDM_POS_MUTE_SRC +: 4];
      rate_q <= I_REG_WDATA[`SDM_POS_RATE +: 2];
    end
  end

  always_ff @(posedge I_MCLK)
  begin
    if (I_SYS_RST || !restore_q)
    begin
      psave_sel_q <= `SDM_RST_PSAVE_SEL;
      fmt_q <= `SDM_RST_FMT;
    end
    else if (wr_ok && I_REG_ADDR == `SDM_ADDR_PSAVE_FMT)
    begin
      psave_sel_q <= I_REG_WDATA[`SDM_BIT_PSAVE_SEL];
      fmt_q <= I_REG_WDATA[`SDM_POS_FMT +: 3];
    end
  end

  always_ff @(posedge I_MCLK)
  begin
    if (I_SYS_RST || !restore_q)
    begin
      opdis_q <= `SDM_RST_OPDIS;
      rolloff_q <= `SDM_RST_ROLLOFF;
    end
    else if (wr_ok && I_REG_ADDR == `SDM_ADDR_OPER_FILT)
    begin
      opdis_q <= I_REG_WDATA[`SDM_BIT_OPDIS];
      rolloff_q <= I_REG_WDATA[`SDM_BIT_ROLLOFF];
    end
  end

  always_ff @(posedge I_MCLK)
  begin
    if (I_SYS_RST || !restore_q)
      invert_q <= `SDM_RST_INVERT;
    else if (wr_ok && I_REG_ADDR == `SDM_ADDR_OUT_PHASE)
      invert_q <= I_REG_WDATA[`SDM_POS_INVERT +: 2];
  end

  always_ff @(posedge I_MCLK)
  begin
    if (I_SYS_RST || !restore_q)
      smute_q <= `SDM_RST_SMUTE;
    else if (wr_ok && I_REG_ADDR == `SDM_ADDR_SOFT_MUTE)
      smute_q <= I_REG_WDATA[`SDM_POS_SMUTE +: 2];
  end

  always_ff @(posedge I_MCLK)
  begin
    if (I_SYS_RST || !restore_q)
      atten_mode_q <= `SDM_RST_ATTEN_MODE;
    else if (wr_ok && I_REG_ADDR == `SDM_ADDR_ATTEN_FLAG)
      atten_mode_q <= I_REG_WDATA[`SDM_BIT_ATTEN_MODE];
  end

  // read mux; silence register has no storage
  always_comb
  begin
    rd_d = 8'h00;
    case (I_REG_ADDR)
      `SDM_ADDR_RST_MUTE_RATE:
      begin
        rd_d[`SDM_BIT_RESTORE] = restore_q;
        rd_d[`SDM_BIT_RESYNC] = resync_q;
        rd_d[`SDM_POS_MUTE_SRC +: 4] = mute_src_q;
        rd_d[`SDM_POS_RATE +: 2] = rate_q;
      end
      `SDM_ADDR_PSAVE_FMT:
      begin
        rd_d[`SDM_BIT_PSAVE_SEL] = psave_sel_q;
        rd_d[`SDM_POS_FMT +: 3] = fmt_q;
      end
      `SDM_ADDR_OPER_FILT:
      begin
        rd_d[`SDM_BIT_OPDIS] = opdis_q;
        rd_d[`SDM_BIT_ROLLOFF] = rolloff_q;
      end
      `SDM_ADDR_OUT_PHASE: rd_d[`SDM_POS_INVERT +: 2] = invert_q;
      `SDM_ADDR_SOFT_MUTE: rd_d[`SDM_POS_SMUTE +: 2] = smute_q;
      `SDM_ADDR_SILENCE: rd_d[`SDM_POS_SILENCE +: 2] = {I_ZERO_R, I_ZERO_L};
      `SDM_ADDR_ATTEN_FLAG: rd_d[`SDM_BIT_ATTEN_MODE] = atten_mode_q;
      default: rd_d = 8'h00;
    endcase
  end

  always_ff @(posedge I_MCLK)
  begin
    if (I_SYS_RST)
    begin
      O_REG_RDATA <= 8'h00;
      O_REG_RVALID <= 1'b0;
    end
    else
    begin
      O_REG_RVALID <= I_REG_RD;
      if (I_REG_RD)
        O_REG_RDATA <= rd_d;
    end
  end

  // sampling clock pin: three stages, change accepted when stages 2 and 3 agree
  always_ff @(posedge I_MCLK)
  begin
    if (I_SYS_RST)
    begin
      lr_s1_q <= 1'b0;
      lr_s2_q <= 1'b0;
      lr_s3_q <= 1'b0;
    end
    else
    begin
      lr_s1_q <= I_LRCK;
      lr_s2_q <= lr_s1_q;
      lr_s3_q <= lr_s2_q;
    end
  end

  always_ff @(posedge I_MCLK)
  begin
    if (I_SYS_RST)
      lr_st_q <= 1'b0;
    else if (lr_s2_q == lr_s3_q)
      lr_st_q <= lr_s3_q;
  end

  assign fs_edge = (lr_s2_q == lr_s3_q) && lr_s3_q && !lr_st_q;

  // eight sampling periods per attenuator step
  always_ff @(posedge I_MCLK)
  begin
    if (I_SYS_RST || O_RESYNC)
    begin
      fs_cnt_q <= 3'h0;
      step_q <= 1'b0;
    end
    else
    begin
      step_q <= fs_edge && (fs_cnt_q == `SDM_STEP_FS_PERIODS);
      if (fs_edge)
        fs_cnt_q <= fs_cnt_q + 3'h1;
    end
  end

  sdm_rate_det u_rate (
    .i_clk(I_MCLK),
    .i_rst(I_SYS_RST),
    .i_restart(O_RESYNC),
    .i_fs_edge(fs_edge),
    .o_rate(det_rate)
  );

  assign att_bus.atten_mode = atten_mode_q;
  assign att_bus.step_tick = step_q;
  assign att_bus.mute = smute_q;
  assign att_bus.level[0] = I_ATTEN_L;
  assign att_bus.level[1] = I_ATTEN_R;

  sdm_atten u_atten (
    .i_clk(I_MCLK),
    .i_rst(I_SYS_RST),
    .att(att_bus)
  );

  assign O_ATTEN_L = att_bus.cur[0];
  assign O_ATTEN_R = att_bus.cur[1];
  assign O_CH_MUTED = att_bus.muted;

  // registered mode outputs
  always_ff @(posedge I_MCLK)
  begin
    if (I_SYS_RST)
    begin
      O_RATE <= SDM_RATE_SINGLE;
      O_FORMAT <= `SDM_RST_FMT;
      O_ROLLOFF <= `SDM_RST_ROLLOFF;
      O_INVERT <= `SDM_RST_INVERT;
      O_ATTEN_MODE <= `SDM_RST_ATTEN_MODE;
    end
    else
    begin
      O_RATE <= (rate_q == `SDM_RST_RATE) ? det_rate : sdm_rate_e'(rate_q);
      O_FORMAT <= fmt_q;
      O_ROLLOFF <= rolloff_q;
      O_INVERT <= invert_q;
      O_ATTEN_MODE <= atten_mode_q;
    end
  end

  // disabled output parks at common mode or at ground
  always_ff @(posedge I_MCLK)
  begin
    if (I_SYS_RST)
    begin
      O_DATA_CLEAR <= 1'b0;
      O_HOLD_COMMON <= 1'b0;
      O_HOLD_GROUND <= 1'b0;
      O_POWER_DOWN <= 1'b0;
    end
    else
    begin
      O_DATA_CLEAR <= opdis_q;
      O_HOLD_COMMON <= opdis_q && psave_sel_q;
      O_HOLD_GROUND <= opdis_q && !psave_sel_q;
      O_POWER_DOWN <= opdis_q && !psave_sel_q;
    end
  end

  // any enabled source mutes the output stage
  always_ff @(posedge I_MCLK)
  begin
    if (I_SYS_RST)
      O_ANALOG_MUTE <= 1'b0;
    else
      O_ANALOG_MUTE <= (mute_src_q[0] && I_CLK_HALT) || (mute_src_q[1] && I_ASYNC_DET)
        || (mute_src_q[2] && I_ZERO_L && I_ZERO_R) || (mute_src_q[3] && opdis_q);
  end
endmodule
`default_nettype wire

// ---- verification/sdm_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module sdm_host_model
(
  input wire logic i_clk,
  output logic o_wr,
  output logic o_rd,
  output logic [6:0] o_addr,
  output logic [7:0] o_wdata,
  input wire logic [7:0] i_rdata,
  input wire logic i_rvalid
);
  initial
  begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 7'h00;
    o_wdata = 8'h00;
  end
  // reserved positions always sent as zero
  function automatic logic [7:0] legal(input logic [6:0] a, input logic [7:0] d);
    case (a)
      7'h11: legal = d & 8'h87;
      7'h12: legal = d & 8'h11;
      7'h13, 7'h14, 7'h15: legal = d & 8'h03;
      7'h16: legal = d & 8'h80;
      default: legal = d;
    endcase
  endfunction
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge i_clk);
    #1;
    o_wr = 1'b1;
    o_addr = a;
    o_wdata = legal(a, d);
    @(posedge i_clk);
    #1;
    o_wr = 1'b0;
    o_wdata = ~o_wdata;
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge i_clk);
    #1;
    o_rd = 1'b1;
    o_addr = a;
    @(posedge i_clk);
    #1;
    o_rd = 1'b0;
    d = (i_rvalid === 1'b1) ? i_rdata : 8'hxx;
  endtask
endmodule
`default_nettype wire

// ---- verification/sdm_top_properties.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "sdm_regs.svh"
module sdm_top_checker
(
  input wire logic I_MCLK,
  input wire logic I_SYS_RST,
  input wire logic I_REG_WR,
  input wire logic I_REG_RD,
  input wire logic [6:0] I_REG_ADDR,
  input wire logic [7:0] I_REG_WDATA,
  input wire logic [7:0] O_REG_RDATA,
  input wire logic O_REG_RVALID,
  input wire logic I_ZERO_L,
  input wire logic I_ZERO_R,
  input wire logic I_CLK_HALT,
  input wire logic I_ASYNC_DET,
  input wire logic [2:0] O_FORMAT,
  input wire logic O_ROLLOFF,
  input wire logic O_ATTEN_MODE,
  input wire logic [7:0] O_ATTEN_L,
  input wire logic [1:0] O_CH_MUTED,
  input wire logic O_ANALOG_MUTE,
  input wire logic O_DATA_CLEAR,
  input wire logic O_HOLD_COMMON,
  input wire logic O_HOLD_GROUND,
  input wire logic O_POWER_DOWN,
  input wire logic O_RESYNC
);
  logic rst_wr;
  logic rst_wr_q;
  logic acc;
  logic src;
  assign rst_wr = I_REG_WR && I_REG_ADDR == `SDM_ADDR_RST_MUTE_RATE && !I_REG_WDATA[7];
  // write right after a restore write is dropped
  assign acc = I_REG_WR && !rst_wr_q;
  assign src = I_CLK_HALT || I_ASYNC_DET || (I_ZERO_L && I_ZERO_R);
  always_ff @(posedge I_MCLK)
  begin
    rst_wr_q <= !I_SYS_RST && rst_wr;
  end
  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (I_SYS_RST);
  property p_restore;
    rst_wr |-> ##3 (O_FORMAT == `SDM_RST_FMT && O_ROLLOFF == `SDM_RST_ROLLOFF && O_ATTEN_MODE == 1'b0);
  endproperty
  a_restore: assert property (p_restore) else $error("restore did not load defaults");
  property p_resync;
    acc && I_REG_ADDR == `SDM_ADDR_RST_MUTE_RATE && I_REG_WDATA[7:6] == 2'b10 |-> ##2 O_RESYNC;
  endproperty
  a_resync: assert property (p_resync) else $error("resync pulse missing");
  property p_pulse;
    O_RESYNC |=> !O_RESYNC;
  endproperty
  a_pulse: assert property (p_pulse) else $error("resync pulse too long");
  property p_fmt;
    acc && I_REG_ADDR == `SDM_ADDR_PSAVE_FMT |-> ##2 O_FORMAT == $past(I_REG_WDATA[2:0], 2);
  endproperty
  a_fmt: assert property (p_fmt) else $error("format not applied");
  property p_filt;
    acc && I_REG_ADDR == `SDM_ADDR_OPER_FILT |-> ##2 O_ROLLOFF == $past(I_REG_WDATA[0], 2);
  endproperty
  a_filt: assert property (p_filt) else $error("rolloff not applied");
  property p_read;
    I_REG_RD |=> O_REG_RVALID;
  endproperty
  a_read: assert property (p_read) else $error("read not answered");
  property p_silence;
    I_REG_RD && I_REG_ADDR == `SDM_ADDR_SILENCE |=> O_REG_RDATA == {6'h00, $past(I_ZERO_R), $past(I_ZERO_L)};
  endproperty
  a_silence: assert property (p_silence) else $error("silence flags wrong");
  property p_amute;
    O_ANALOG_MUTE |-> $past(src) || $past(src, 2) || O_DATA_CLEAR || $past(O_DATA_CLEAR);
  endproperty
  a_amute: assert property (p_amute) else $error("analog mute without source");
  property p_hold;
    O_HOLD_COMMON || O_HOLD_GROUND |-> O_DATA_CLEAR && O_HOLD_GROUND == O_POWER_DOWN
      && !(O_HOLD_COMMON && O_HOLD_GROUND);
  endproperty
  a_hold: assert property (p_hold) else $error("disable hold state wrong");
  property p_step;
    $changed(O_ATTEN_L) |=> $stable(O_ATTEN_L) [*3];
  endproperty
  a_step: assert property (p_step) else $error("attenuator stepped too fast");
  property p_muted;
    $stable(O_ATTEN_MODE) |-> O_CH_MUTED[0] ==
      ($past(O_ATTEN_L) <= (O_ATTEN_MODE ? `SDM_MUTE_THR_WIDE : `SDM_MUTE_THR_FINE));
  endproperty
  a_muted: assert property (p_muted) else $error("mute flag wrong");
  c_restore: cover property (rst_wr);
  c_resync: cover property (O_RESYNC);
  c_muted: cover property (O_CH_MUTED[0]);
endmodule
bind sdm_top sdm_top_checker i_sdm_top_checker (.I_MCLK, .I_SYS_RST, .I_REG_WR, .I_REG_RD, .I_REG_ADDR,
  .I_REG_WDATA, .O_REG_RDATA, .O_REG_RVALID, .I_ZERO_L, .I_ZERO_R, .I_CLK_HALT, .I_ASYNC_DET, .O_FORMAT,
  .O_ROLLOFF, .O_ATTEN_MODE, .O_ATTEN_L, .O_CH_MUTED, .O_ANALOG_MUTE, .O_DATA_CLEAR, .O_HOLD_COMMON,
  .O_HOLD_GROUND, .O_POWER_DOWN, .O_RESYNC);
`default_nettype wire

// ---- verification/sdm_top_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module sdm_top_tb_top;
  import sdm_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr, rd, rvalid, lrck, zl, zr, halt, asy, roll, amode, amt, dclr, hcm, hgnd, pdn, resync;
  logic [6:0] addr;
  logic [7:0] wdata, rdata, atl, atr, oatl, oatr, d;
  logic [2:0] fmt;
  logic [1:0] inv, muted;
  sdm_rate_e rate;
  logic [7:0] m [16:22];
  int error_cnt = 0;
  int checked = 0;
  int seed = 48;
  int lr_half = 4;
  int n;
  int halves [7] = '{64, 96, 128, 192, 256, 384, 576};
  int rates [7] = '{3, 3, 2, 2, 1, 1, 1};
  always #20 clk = ~clk;
  always
  begin
    repeat (lr_half) @(posedge clk);
    #1 lrck = ~lrck;
  end
  sdm_top i_sdm_top (.I_MCLK(clk), .I_SYS_RST(rst), .I_REG_WR(wr), .I_REG_RD(rd), .I_REG_ADDR(addr),
    .I_REG_WDATA(wdata), .O_REG_RDATA(rdata), .O_REG_RVALID(rvalid), .I_LRCK(lrck), .I_ZERO_L(zl),
    .I_ZERO_R(zr), .I_CLK_HALT(halt), .I_ASYNC_DET(asy), .I_ATTEN_L(atl), .I_ATTEN_R(atr), .O_RATE(rate),
    .O_FORMAT(fmt), .O_ROLLOFF(roll), .O_INVERT(inv), .O_ATTEN_MODE(amode), .O_ATTEN_L(oatl),
    .O_ATTEN_R(oatr), .O_CH_MUTED(muted), .O_ANALOG_MUTE(amt), .O_DATA_CLEAR(dclr), .O_HOLD_COMMON(hcm),
    .O_HOLD_GROUND(hgnd), .O_POWER_DOWN(pdn), .O_RESYNC(resync));
  sdm_host_model i_sdm_host_model (.i_clk(clk), .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wdata),
    .i_rdata(rdata), .i_rvalid(rvalid));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (error_cnt == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  function automatic logic [7:0] exp_rd(input int a);
    if (a == 21)
      return {6'h00, zr, zl};
    return (a >= 16 && a <= 22) ? m[a] : 8'h00;
  endfunction
  task automatic mwr(input int a, input logic [7:0] v);
    i_sdm_host_model.wr(a[6:0], v);
    if (a == 16 && !v[7])
      m = '{8'hc0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    else if (a >= 16 && a <= 22 && a != 21)
      m[a] = i_sdm_host_model.legal(a[6:0], v) | ((a == 16) ? 8'h40 : 8'h00);
  endtask
  task automatic rdchk(input int a);
    i_sdm_host_model.rd(a[6:0], d);
    chk(d, exp_rd(a));
  endtask
  task automatic wait_att(input logic [7:0] t, input int bound);
    n = 0;
    while (oatl !== t && n < bound)
    begin
      @(posedge clk);
      #1 n++;
    end
    chk(oatl, t);
  endtask
  initial
  begin
    {lrck, zl, zr, halt, asy} = 5'h00;
    atl = 8'hff;
    atr = 8'hff;
    m = '{8'hc0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    for (int a = 16; a < 24; a++) rdchk(a);
    chk({6'h00, rate}, 8'h01);
    for (int i = 0; i < 40; i++)
    begin
      n = 16 + ($unsigned($random(seed)) % 8);
      d = 8'($random(seed));
      {zl, zr, halt, asy} = 4'($random(seed));
      if (n == 16)
        d[7:6] = 2'b11;
      mwr(n, d);
      rdchk(n);
      chk({amode, dclr, hcm, hgnd, pdn, roll, inv}, {m[22][7], m[18][4], m[18][4] & m[17][7],
        {2{m[18][4] & !m[17][7]}}, m[18][0], m[19][1:0]});
      chk({amt, 4'h0, fmt}, {|(m[16][5:2] & {m[18][4], zl & zr, asy, halt}), 4'h0, m[17][2:0]});
      if (m[16][1:0] != 2'b00)
        chk({6'h00, rate}, {6'h00, m[16][1:0]});
    end
    mwr(16, 8'h7f);
    for (int a = 16; a < 23; a++) rdchk(a);
    mwr(17, 8'h05);
    mwr(16, 8'hbc);
    n = 0;
    while (resync !== 1'b1 && n < 8)
    begin
      @(posedge clk);
      #1 n++;
    end
    chk({7'h00, resync}, 8'h01);
    rdchk(17);
    rdchk(16);
    for (int k = 0; k < 7; k++)
    begin
      lr_half = halves[k];
      repeat (8 * lr_half) @(posedge clk);
      #1 chk({6'h00, rate}, rates[k][7:0]);
    end
    lr_half = 4;
    atl = 8'h90;
    wait_att(8'h90, 12000);
    chk(oatr, 8'hff);
    mwr(20, 8'h01);
    wait_att(8'h00, 1500);
    @(posedge clk);
    #1 chk({6'h00, muted}, 8'h01);
    atl = 8'ha0;
    repeat (200) @(posedge clk);
    #1 chk(oatl, 8'h00);
    mwr(20, 8'h00);
    wait_att(8'ha0, 3000);
    chk({7'h00, n >= 30 * 64 && n <= 33 * 64}, 8'h01);
    mwr(22, 8'h80);
    rdchk(22);
    chk({7'h00, amode}, 8'h01);
    atl = 8'h9a;
    wait_att(8'h00, 1000);
    @(posedge clk);
    #1 chk({6'h00, muted}, 8'h01);
    tally_and_finish();
  end
  initial
  begin
    #(60000 * 40);
    error_cnt++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
